// ---- brg_pkg.sv ----
`default_nettype none
package brg_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DIVISOR = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;

  localparam int         REG_W         = 8;
  localparam int         RATIO_W       = 13;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET    = 8'h00;

  // serial_timer_control fields
  localparam int MPE_BIT   = 2;
  localparam int TSEL_HI   = 1;
  localparam int TSEL_LO   = 0;
  // mode register fields
  localparam int PSEL_HI   = 1;
  localparam int PSEL_LO   = 0;
  localparam int DOUBLE_B  = 2;
  localparam int SYNC_B    = 3;
  localparam int MPFMT_B   = 4;
  localparam logic [7:0] MODE_MASK = 8'h1f;

  // base-clock cycles per prescaled cycle, before the divisor
  localparam logic [RATIO_W-1:0] ASYNC_BASE = 13'h0020;
  localparam logic [RATIO_W-1:0] SYNC_BASE  = 13'h0004;

  // cycles per prescaled tick: (64 or 8) * 2^(2n-1), doubled when dbl is set and n != 0
  function automatic logic [RATIO_W-1:0] pre_ratio(
    input logic [1:0] n,
    input logic       dbl,
    input logic       sync);
    logic [2:0] sh;
    sh = {n, 1'b0} + {2'b00, dbl && (n != 2'b00)};
    pre_ratio = (sync ? SYNC_BASE : ASYNC_BASE) << sh;
  endfunction : pre_ratio
endpackage : brg_pkg
`default_nettype wire

// ---- prescale_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface prescale_if;
  import brg_pkg::*;
  logic               base_en;
  logic [RATIO_W-1:0] ratio;
  logic               pre_tick;
  modport ctrl (output base_en, output ratio, input pre_tick);
  modport div  (input base_en, input ratio, output pre_tick);
endinterface : prescale_if
`default_nettype wire

// ---- brg_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
module brg_prescaler (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  prescale_if.div    pif
);
  import brg_pkg::*;

  logic [RATIO_W-1:0] cnt_q;
  logic [RATIO_W-1:0] cnt_d;
  logic               tick_q;
  logic               tick_d;

  assign pif.pre_tick = tick_q;

  // a ratio cut below the current count ends the period at once
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (pif.base_en) begin  // see R5
      if (cnt_q >= pif.ratio - 13'h0001) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_PRE_PERIOD: assert property (  // see R5
    @(posedge clk_i) disable iff (rst_i)
    tick_d && $stable(pif.ratio) && $past(cnt_q) < pif.ratio - 13'h0001
    |-> cnt_q == pif.ratio - 13'h0001)
    else $error("prescaler fired at wrong count");
endmodule : brg_prescaler
`default_nettype wire

// ---- serial_bit_rate_generator.sv ----
// What this block does
// R1: async bit period is 64 x 2^(2n-1) x (divisor+1) base clocks.
// R2: sync bit period is 8 x 2^(2n-1) x (divisor+1) base clocks.
// R3: the divisor is 8 bits and every value 0 to 255 is used as written.
// R4: n of zero uses the system clock, any other n the peripheral clock.
// R5: n picks /1, /4, /16 or /64, or /1, /8, /32 or /128 when doubled.
// R6: software expects no continuous sync transfer at n zero, divisor zero.
// R7: software should pick settings within one percent of the target rate.
// R8: the serial/timer control register is read/write and resets to zero.
// R9: with multiproc enable clear, framing is off whatever the format bit.
// R10: with it set, framing is multiprocessor only if the format bit is set.
// R11: control bits 1:0 go to the timers as clock select, not to the rate.
// R12: divisor counts down per prescaled tick, reloads at zero, ticks once.
`timescale 1ns/1ns
`default_nettype none
module serial_bit_rate_generator #(
  parameter int PCLK_DIV = 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  output var  logic        ack_o,
  output var  logic        bit_tick_o,
  output var  logic        sync_mode_o,
  output var  logic        multiproc_enable_o,
  output var  logic        multiproc_frame_o,
  output var  logic [1:0]  timer_clock_select_o
);
  import brg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [REG_W-1:0] control_q, control_d;
  logic [REG_W-1:0] divisor_q, divisor_d;
  logic [REG_W-1:0] mode_q, mode_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             ack_q, ack_d;
  logic             wr;

  function automatic logic [REG_W-1:0] read_reg(
    input logic [7:0]       a,
    input logic [REG_W-1:0] ctl,
    input logic [REG_W-1:0] dv,
    input logic [REG_W-1:0] md,
    input logic [REG_W-1:0] st);
    if (a == ADDR_CONTROL) begin
      read_reg = ctl;
    end else if (a == ADDR_DIVISOR) begin
      read_reg = dv;
    end else if (a == ADDR_MODE) begin
      read_reg = md;
    end else if (a == ADDR_STATUS) begin
      read_reg = st;
    end else begin
      read_reg = '0;
    end
  endfunction : read_reg

  // rate state
  logic             pclk_q, pclk_d;
  logic [REG_W-1:0] cnt_q, cnt_d;
  logic             tick_q, tick_d;
  logic             mpe_q, mpe_d;
  logic             frame_q, frame_d;
  logic             sync_q, sync_d;
  logic [1:0]       tsel_q, tsel_d;
  logic [1:0]       n_sel;

  prescale_if pif ();

  brg_prescaler u_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pif   (pif.div)
  );

  assign n_sel = mode_q[PSEL_HI:PSEL_LO];

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: one-wait ack, ack drops the cycle after
  always_comb begin
    ack_d     = cyc_i && stb_i && !ack_q;
    wr        = ack_d && we_i && sel_i[0];
    control_d = control_q;
    divisor_d = divisor_q;
    mode_d    = mode_q;
    if (wr && adr_i == ADDR_CONTROL) begin
      control_d = dat_i[REG_W-1:0];  // see R8
    end else if (wr && adr_i == ADDR_DIVISOR) begin
      divisor_d = dat_i[REG_W-1:0];  // see R3
    end else if (wr && adr_i == ADDR_MODE) begin
      mode_d = dat_i[REG_W-1:0] & MODE_MASK;
    end
    rdata_d = {24'h000000,
               read_reg(adr_i, control_q, divisor_q, mode_q, cnt_q)};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_q <= CONTROL_RESET;  // see R8
      divisor_q <= DIVISOR_RESET;
      mode_q    <= MODE_RESET;
      rdata_q   <= '0;
      ack_q     <= 1'b0;
    end else begin
      control_q <= control_d;
      divisor_q <= divisor_d;
      mode_q    <= mode_d;
      rdata_q   <= rdata_d;
      ack_q     <= ack_d;
    end
  end

  assign dat_o = rdata_q;
  assign ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////
  // peripheral clock enable and bit-rate down-counter
  always_comb begin
    pclk_d = (PCLK_DIV == 1) ? 1'b1 : !pclk_q;
    pif.base_en = (n_sel == 2'b00) ? 1'b1 : pclk_q;  // see R4
    pif.ratio   = pre_ratio(n_sel, mode_q[DOUBLE_B],
                            mode_q[SYNC_B]);  // see R1 see R2 see R5
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (pif.pre_tick) begin
      if (cnt_q == '0) begin
        cnt_d  = divisor_q;  // see R12 see R3
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 8'h01;
      end
    end
    // timer select is passed through only; the rate never reads it
    mpe_d   = control_d[MPE_BIT];
    frame_d = control_d[MPE_BIT] && mode_d[MPFMT_B];  // see R9 see R10
    sync_d  = mode_d[SYNC_B];
    tsel_d  = control_d[TSEL_HI:TSEL_LO];  // see R11
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_q  <= 1'b0;
      cnt_q   <= '0;
      tick_q  <= 1'b0;
      mpe_q   <= 1'b0;
      frame_q <= 1'b0;
      sync_q  <= 1'b0;
      tsel_q  <= 2'b00;
    end else begin
      pclk_q  <= pclk_d;
      cnt_q   <= cnt_d;
      tick_q  <= tick_d;
      mpe_q   <= mpe_d;
      frame_q <= frame_d;
      sync_q  <= sync_d;
      tsel_q  <= tsel_d;
    end
  end

  assign bit_tick_o           = tick_q;
  assign sync_mode_o          = sync_q;
  assign multiproc_enable_o   = mpe_q;
  assign multiproc_frame_o    = frame_q;
  assign timer_clock_select_o = tsel_q;

  ////////////////////////////////////////////////////////////////////////
  AST_ACK_PULSE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  AST_ACK_ANSWER: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");

  AST_CONTROL_RESET: assert property (  // see R8
    @(posedge clk_i)
    rst_i |=> control_q == CONTROL_RESET && !multiproc_enable_o)
    else $error("control register not cleared by reset");

  AST_CONTROL_WRITE: assert property (  // see R8
    @(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == ADDR_CONTROL
    |=> ##1 control_q == $past(dat_i[REG_W-1:0], 2))
    else $error("control write not stored");

  AST_MPE_OFF: assert property (  // see R9
    @(posedge clk_i) disable iff (rst_i)
    !control_q[MPE_BIT] |-> !multiproc_frame_o)
    else $error("multiprocessor frame used while disabled");

  AST_MPE_ON: assert property (  // see R10
    @(posedge clk_i) disable iff (rst_i)
    multiproc_frame_o == (multiproc_enable_o && mode_q[MPFMT_B]))
    else $error("multiprocessor frame select wrong");

  AST_TIMER_SEL: assert property (  // see R11
    @(posedge clk_i) disable iff (rst_i)
    timer_clock_select_o == control_q[TSEL_HI:TSEL_LO])
    else $error("timer clock select not passed on");

  AST_RELOAD: assert property (  // see R12
    @(posedge clk_i) disable iff (rst_i)
    pif.pre_tick && cnt_q == '0 |=> bit_tick_o && cnt_q == $past(divisor_q))
    else $error("divisor not reloaded with a tick");

  AST_TICK_CAUSE: assert property (  // see R1 see R2
    @(posedge clk_i) disable iff (rst_i)
    bit_tick_o |-> $past(pif.pre_tick) && $past(cnt_q) == '0)
    else $error("bit tick without counter expiry");

  AST_BASE_SYS: assert property (  // see R4
    @(posedge clk_i) disable iff (rst_i)
    n_sel == 2'b00 |-> pif.base_en)
    else $error("index zero not on system clock");

  AST_RATIO: assert property (  // see R1 see R2 see R5
    @(posedge clk_i) disable iff (rst_i)
    mode_q[PSEL_HI:0] == 2'b01 && !mode_q[DOUBLE_B]
    |-> pif.ratio == (mode_q[SYNC_B] ? 13'h0010 : 13'h0080))
    else $error("prescale ratio wrong for index one");
endmodule : serial_bit_rate_generator
`default_nettype wire

// ---- brg_tick_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
// far transceiver side: times the gap between bit ticks
module brg_tick_monitor (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  output var  int   period_o,
  output var  int   ticks_o
);
  int gap;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap      <= 0;
      period_o <= 0;
      ticks_o  <= 0;
    end else if (tick_i) begin
      period_o <= gap + 1;
      gap      <= 0;
      ticks_o  <= ticks_o + 1;
    end else begin
      gap <= gap + 1;
    end
  end
endmodule : brg_tick_monitor
`default_nettype wire

// ---- serial_bit_rate_generator_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_bit_rate_generator_tb_top;
  import brg_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, tick, sync_o, mpe_o, mpf_o;
  logic [1:0]  tsel_o;
  int          bad_count = 0, total_checks = 0, period, ticks;
  // prescaler division for mode bits {double, n}
  int          div_tab [8] = '{1, 4, 16, 64, 1, 8, 32, 128};
  always #25 clk_i = ~clk_i;
  serial_bit_rate_generator uut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .bit_tick_o(tick), .sync_mode_o(sync_o),
    .multiproc_enable_o(mpe_o), .multiproc_frame_o(mpf_o),
    .timer_clock_select_o(tsel_o));
  brg_tick_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
    .period_o(period), .ticks_o(ticks));
  //////////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // classic cycle: hold everything until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
          input logic [7:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (i >= 50) begin
      bad_count++;
      final_report();
    end
  endtask : wb
  // second full period after a rate change is the steady one
  task rate(input logic [7:0] md, input logic [7:0] dv);
    int c0, i, p, r;
    wb(1'b1, ADDR_DIVISOR, 4'h1, dv);
    wb(1'b1, ADDR_MODE, 4'h1, md);
    // clocks per prescaled tick: (64 or 8) x 2^(2n-1), n from the divider
    r = (md[3] ? 8 : 64) * div_tab[md[2:0]] / 2;
    p = r * (dv + 1);
    c0 = ticks;
    i = 0;
    // the old count may first run out at the new prescale: allow for it
    while (ticks < c0 + 3 && i < 3 * p + 256 * r + 200) begin
      @(posedge clk_i);
      i++;
    end
    if (ticks < c0 + 3) begin
      bad_count++;
      final_report();
    end
    chk("bit period", p, period);
    chk("sync mode", md[3], sync_o);
  endtask : rate
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_CONTROL, 4'h1, 8'h00);
    chk("control reset", 32'h00, rd);
    wb(1'b0, ADDR_DIVISOR, 4'h1, 8'h00);
    chk("divisor reset", 32'hff, rd);
    wb(1'b1, ADDR_CONTROL, 4'h1, 8'hfb);
    wb(1'b0, ADDR_CONTROL, 4'h1, 8'h00);
    chk("control rw", 32'hfb, rd);
    chk("timer select", 2'b11, tsel_o);
    chk("mp enable", 1'b0, mpe_o);
    wb(1'b1, ADDR_CONTROL, 4'h0, 8'h00);
    wb(1'b0, ADDR_CONTROL, 4'h1, 8'h00);
    chk("byte lane off", 32'hfb, rd);
    wb(1'b0, 8'h10, 4'h1, 8'h00);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ADDR_CONTROL, 4'h1, {5'h00, i[1], 2'b00});
      wb(1'b1, ADDR_MODE, 4'h1, {3'h0, i[0], 4'h0});
      chk("mp enable", i[1], mpe_o);
      chk("mp frame", i[1] & i[0], mpf_o);
    end
    // second reset in mid-run must clear what the loop left set
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_CONTROL, 4'h1, 8'h00);
    chk("control re-reset", 32'h00, rd);
    chk("mp frame reset", 1'b0, mpf_o);
    wb(1'b0, ADDR_STATUS, 4'h1, 8'h00);
    chk("status reset", 32'h00, rd);
    // n zero with divisor zero is kept out of sync mode
    rate(8'h00, 8'h00);
    rate(8'h00, 8'h03);
    // 9600 bit/s from 20 MHz lands 0.16 percent off
    rate(8'h00, 8'h40);
    rate(8'h04, 8'h01);
    rate(8'h08, 8'h01);
    rate(8'h01, 8'h00);
    rate(8'h05, 8'h00);
    rate(8'h07, 8'h00);
    rate(8'h0a, 8'h02);
    // longest count last, so no later change waits out its remainder
    rate(8'h08, 8'hff);
    final_report();
  end
endmodule : serial_bit_rate_generator_tb_top
`default_nettype wire
